// ### design/svpl_pkg.sv
// Shared constants, types and helpers of the protection vote and priority logic
package svpl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Structure
  localparam int N_GRP  = 4;
  localparam int N_BUS  = 3;
  localparam int N_SW   = 4;
  localparam int N_PATH = 2;
  localparam logic [3:0] GRP_VOTE_K = 4'h2;
  localparam logic [3:0] BUS_VOTE_K = 4'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS  = 10;
  localparam int SDB_TIMEOUT_NS = 2000;
  // Longest time, so the division rounds down
  localparam int SDB_TIMEOUT_CYC = SDB_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int TMO_W           = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Register port
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_ALARM  = 4'h4;
  localparam logic [31:0] ALARM_RST = 32'h0000_0000;
  localparam int ST_SDB_LSB  = 0;
  localparam int ST_MIB_BIT  = 3;
  localparam int ST_ART_BIT  = 4;
  localparam int ST_AESF_BIT = 5;
  localparam int ST_SRC_LSB  = 6;
  localparam int ST_PCS_BIT  = 8;
  localparam int AL_SDB_LSB  = 0;
  localparam int AL_MIB_BIT  = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Monitoring answer layout
  localparam int MIB_W        = 16;
  localparam int MIB_FB_LSB   = 0;
  localparam int MIB_SDB_LSB  = 4;
  localparam int MIB_VOTE_LSB = 7;

  typedef enum logic [1:0] {
    SVPL_SRC_NONE,
    SVPL_SRC_PCS,
    SVPL_SRC_AUTO,
    SVPL_SRC_MAN
  } svpl_src_e;

  function automatic logic svpl_k_of_n(input logic [7:0] v,
                                       input logic [3:0] k);
    return 4'($countones(v)) >= k;
  endfunction

  // Manual first, then automatic, plant control last and only when enabled
  function automatic svpl_src_e svpl_prio(input logic man,
                                          input logic auto_dmd,
                                          input logic pcs_en,
                                          input logic pcs_cmd);
    if (man) return SVPL_SRC_MAN;
    if (auto_dmd) return SVPL_SRC_AUTO;
    if (pcs_en && pcs_cmd) return SVPL_SRC_PCS;
    return SVPL_SRC_NONE;
  endfunction

endpackage

// ### design/svpl_vote_if.sv
// Carrier between the demand source and one voting unit
`timescale 1ns/100ps
`default_nettype none
interface svpl_vote_if;
  logic [svpl_pkg::N_BUS-1:0][svpl_pkg::N_GRP-1:0] dmd;
  logic [svpl_pkg::N_BUS-1:0][svpl_pkg::N_GRP-1:0] vld;
  logic [svpl_pkg::N_BUS-1:0]                      fail;
  logic [svpl_pkg::N_BUS-1:0]                      vote;
  modport src   (output dmd, output vld, output fail, input vote);
  modport voter (input dmd, input vld, input fail, output vote);
endinterface
`default_nettype wire

// ### design/svpl_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module svpl_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } svpl_sync_s;

  svpl_sync_s st_r;
  svpl_sync_s st_nxt;

  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;
endmodule // svpl_sync
`default_nettype wire

// ### design/svpl_voter.sv
// Voting unit: coincidence vote of the group demands on each bus
`timescale 1ns/100ps
`default_nettype none
module svpl_voter (
  input wire logic  sys_clk,
  input wire logic  rst,
  svpl_vote_if.voter vif
);
  typedef struct packed {
    logic [svpl_pkg::N_BUS-1:0] vote;
  } svpl_vst_s;

  svpl_vst_s st_r;
  svpl_vst_s st_nxt;
  logic [svpl_pkg::N_BUS-1:0][svpl_pkg::N_GRP-1:0] eff;

  always_comb begin
    st_nxt = st_r;
    for (int b = 0; b < svpl_pkg::N_BUS; b++) begin
      // Invalid or stale data counts as a demand, so faults vote to trip
      eff[b] = vif.dmd[b] | ~vif.vld[b]
             | {svpl_pkg::N_GRP{vif.fail[b]}};
      st_nxt.vote[b] = svpl_pkg::svpl_k_of_n({4'h0, eff[b]},
                                             svpl_pkg::GRP_VOTE_K);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign vif.vote = st_r.vote;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  for (genvar g = 0; g < svpl_pkg::N_BUS; g++) begin : g_chk
    chk_pair_votes: assert property (
      $countones(vif.dmd[g] & vif.vld[g]) >= 2 |=> vif.vote[g])
      else $error("two valid demands did not vote");
    chk_single_quiet: assert property (
      (&vif.vld[g]) && !vif.fail[g] && $countones(vif.dmd[g]) < 2
      |=> !vif.vote[g])
      else $error("vote without coincidence");
    chk_fail_forces: assert property (
      vif.fail[g] |=> vif.vote[g])
      else $error("failed bus did not force vote");
    chk_stale_counts: assert property (
      $countones(vif.dmd[g] | ~vif.vld[g]) >= 2 |=> vif.vote[g])
      else $error("invalid input not taken as demand");
  end
endmodule // svpl_voter
`default_nettype wire

// ### design/svpl_top.sv
// Division vote, equipment interface and actuation priority logic
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module svpl_top #(
  parameter logic [15:0] SDB_TMO_CYC = 16'(svpl_pkg::SDB_TIMEOUT_CYC)
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire logic [2:0][3:0]      sdb_rt_dmd,
  input  wire logic [2:0][3:0]      sdb_esf_dmd,
  input  wire logic [2:0][3:0]      sdb_vld,
  input  wire logic [2:0]           sdb_beat,
  input  wire logic                 man_rt,
  input  wire logic                 man_esf,
  input  wire logic                 pcs_enable,
  input  wire logic                 pcs_rt_open,
  input  wire logic [1:0]           pcs_esf_act,
  input  wire logic                 pcs_phb_open,
  input  wire logic                 rtb_closed,
  input  wire logic                 phb_closed,
  input  wire logic [1:0]           esf_pos,
  input  wire logic                 mib_poll,
  input  wire logic                 mib_err,
  input  wire logic [3:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output var  logic [31:0]          reg_rdata,
  output var  logic                 rtb_uv_out,
  output var  logic                 rtb_shunt_out,
  output var  logic [3:0]           esf_sw_out,
  output var  logic                 phb_uv_out,
  output var  logic                 phb_shunt_out,
  output var  logic [2:0]           sdb_alarm,
  output var  logic                 mib_alarm,
  output var  logic                 mib_rsp_vld,
  output var  logic [15:0]          mib_rsp_data
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [2:0][15:0]     tmo;
    logic [2:0]           beat;
    logic [2:0]           sdb_al;
    logic                 mib_dead;
    logic                 mib_al;
    logic                 poll;
    logic [1:0]           warm;
    logic                 rtb_uv;
    logic                 rtb_sh;
    logic [3:0]           sw;
    logic                 phb_uv;
    logic                 phb_sh;
    svpl_pkg::svpl_src_e  rt_src;
    logic                 rsp_vld;
    logic [15:0]          rsp;
    logic [31:0]          rdata;
  } svpl_top_s;

  svpl_top_s st_r;
  svpl_top_s st_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation

  localparam int SYNC_W = 52;

  logic [SYNC_W-1:0] sq;
  logic [2:0][3:0]   s_rt;
  logic [2:0][3:0]   s_esf;
  logic [2:0][3:0]   s_vld;
  logic [2:0]        s_beat;
  logic              s_man_rt;
  logic              s_man_esf;
  logic              s_pcs_en;
  logic              s_pcs_rt;
  logic [1:0]        s_pcs_esf;
  logic              s_pcs_phb;
  logic              s_rtb_fb;
  logic              s_phb_fb;
  logic [1:0]        s_esf_fb;
  logic              s_poll;
  logic              s_mib_err;

  svpl_sync #(
    .W (SYNC_W)
  ) u_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .d       ({sdb_rt_dmd, sdb_esf_dmd, sdb_vld, sdb_beat, man_rt, man_esf,
               pcs_enable, pcs_rt_open, pcs_esf_act, pcs_phb_open,
               rtb_closed, phb_closed, esf_pos, mib_poll, mib_err}),
    .q       (sq)
  );

  // Manual switches pass the same two-stage synchroniser as every other pin except the register port
  assign {s_rt, s_esf, s_vld, s_beat, s_man_rt, s_man_esf,
          s_pcs_en, s_pcs_rt, s_pcs_esf, s_pcs_phb,
          s_rtb_fb, s_phb_fb, s_esf_fb, s_poll, s_mib_err} = sq;

  ////////////////////////////////////////////////////////////////////////////
  // Data bus health and voting units

  logic [2:0] sdb_fail;

  always_comb begin
    for (int b = 0; b < svpl_pkg::N_BUS; b++) begin
      sdb_fail[b] = (st_r.tmo[b] == SDB_TMO_CYC);
    end
  end

  svpl_vote_if rt_if ();
  svpl_vote_if esf_if ();

  // Four group demands per bus, one set per voting unit
  assign rt_if.dmd   = s_rt;
  assign rt_if.vld   = s_vld;
  assign rt_if.fail  = sdb_fail;
  assign esf_if.dmd  = s_esf;
  assign esf_if.vld  = s_vld;
  assign esf_if.fail = sdb_fail;

  svpl_voter u_rt_vote (
    .sys_clk (sys_clk),
    .rst     (rst),
    .vif     (rt_if.voter)
  );

  svpl_voter u_esf_vote (
    .sys_clk (sys_clk),
    .rst     (rst),
    .vif     (esf_if.voter)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Equipment interface: vote copies, fail-safe, priority

  logic                auto_rt;
  logic                auto_esf;
  svpl_pkg::svpl_src_e src_rt;
  svpl_pkg::svpl_src_e src_a;
  svpl_pkg::svpl_src_e src_b;
  svpl_pkg::svpl_src_e src_phb;
  logic                al_clr_sel;
  logic [2:0]          al_clr;

  // A failed bus forces demand even where the copies still disagree
  assign auto_rt  = svpl_pkg::svpl_k_of_n({5'h00, rt_if.vote},
                                          svpl_pkg::BUS_VOTE_K)
                  | (|sdb_fail);
  assign auto_esf = svpl_pkg::svpl_k_of_n({5'h00, esf_if.vote},
                                          svpl_pkg::BUS_VOTE_K)
                  | (|sdb_fail);

  // Plain gating, no processor in the path
  assign src_rt  = svpl_pkg::svpl_prio(s_man_rt, auto_rt, s_pcs_en,
                                       s_pcs_rt);
  assign src_a   = svpl_pkg::svpl_prio(s_man_esf, auto_esf, s_pcs_en,
                                       s_pcs_esf[0]);
  assign src_b   = svpl_pkg::svpl_prio(s_man_esf, auto_esf, s_pcs_en,
                                       s_pcs_esf[1]);
  assign src_phb = svpl_pkg::svpl_prio(s_man_esf, auto_esf, s_pcs_en,
                                       s_pcs_phb);

  assign al_clr_sel = reg_wr && (reg_addr == svpl_pkg::REG_ALARM);
  assign al_clr     = al_clr_sel ? reg_wdata[svpl_pkg::AL_SDB_LSB +: 3]
                                 : 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_nxt         = st_r;
    st_nxt.beat    = s_beat;
    st_nxt.rsp_vld = 1'b0;
    st_nxt.rdata   = 32'h0000_0000;

    // Watchdog per bus; saturates so the failure stays until traffic
    for (int b = 0; b < svpl_pkg::N_BUS; b++) begin
      if (s_beat[b] != st_r.beat[b]) begin
        st_nxt.tmo[b] = 16'h0000;
      end else if (!sdb_fail[b]) begin
        st_nxt.tmo[b] = st_r.tmo[b] + 16'h0001;
      end
    end

    // Sticky alarms: a new failure beats a clear in the same cycle
    st_nxt.sdb_al = (st_r.sdb_al & ~al_clr) | sdb_fail;
    st_nxt.mib_al = (st_r.mib_al
                  & ~(al_clr_sel && reg_wdata[svpl_pkg::AL_MIB_BIT]))
                  | s_mib_err;

    // Silence holds until reset; answering a broken bus helps nobody
    st_nxt.mib_dead = st_r.mib_dead | s_mib_err;

    // Energised means healthy; any active source drops the output
    st_nxt.rt_src = src_rt;
    st_nxt.rtb_uv = (src_rt == svpl_pkg::SVPL_SRC_NONE);
    st_nxt.rtb_sh = (src_rt == svpl_pkg::SVPL_SRC_NONE);
    st_nxt.sw     = {{2{src_b == svpl_pkg::SVPL_SRC_NONE}},
                     {2{src_a == svpl_pkg::SVPL_SRC_NONE}}};
    st_nxt.phb_uv = (src_phb == svpl_pkg::SVPL_SRC_NONE);
    st_nxt.phb_sh = (src_phb == svpl_pkg::SVPL_SRC_NONE);

    // Slave only: speak when polled, never on our own
    // Poll history is stale until the synchroniser has refilled after reset
    st_nxt.poll = s_poll;
    st_nxt.warm = (st_r.warm == 2'h3) ? st_r.warm : st_r.warm + 2'h1;
    if ((s_poll != st_r.poll) && (st_r.warm == 2'h3)
        && !st_r.mib_dead && !s_mib_err) begin
      st_nxt.rsp_vld = 1'b1;
      st_nxt.rsp     = 16'h0000;
      st_nxt.rsp[svpl_pkg::MIB_FB_LSB +: 4] =
        {s_esf_fb, s_phb_fb, s_rtb_fb};
      st_nxt.rsp[svpl_pkg::MIB_SDB_LSB +: 3]  = sdb_fail;
      st_nxt.rsp[svpl_pkg::MIB_VOTE_LSB +: 2] = {auto_esf, auto_rt};
    end

    if (reg_rd) begin
      unique case (reg_addr)
        svpl_pkg::REG_STATUS: begin
          st_nxt.rdata[svpl_pkg::ST_SDB_LSB +: 3]  = sdb_fail;
          st_nxt.rdata[svpl_pkg::ST_MIB_BIT]       = st_r.mib_dead;
          st_nxt.rdata[svpl_pkg::ST_ART_BIT]       = auto_rt;
          st_nxt.rdata[svpl_pkg::ST_AESF_BIT]      = auto_esf;
          st_nxt.rdata[svpl_pkg::ST_SRC_LSB +: 2]  = st_r.rt_src;
          st_nxt.rdata[svpl_pkg::ST_PCS_BIT]       = s_pcs_en;
        end
        svpl_pkg::REG_ALARM: begin
          st_nxt.rdata[svpl_pkg::AL_SDB_LSB +: 3]  = st_r.sdb_al;
          st_nxt.rdata[svpl_pkg::AL_MIB_BIT]       = st_r.mib_al;
        end
        default: begin
          st_nxt.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers; reset leaves every output de-energised

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r        <= '0;
      st_r.sdb_al <= svpl_pkg::ALARM_RST[2:0];
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata     = st_r.rdata;
  assign rtb_uv_out    = st_r.rtb_uv;
  assign rtb_shunt_out = st_r.rtb_sh;
  assign esf_sw_out    = st_r.sw;
  assign phb_uv_out    = st_r.phb_uv;
  assign phb_shunt_out = st_r.phb_sh;
  assign sdb_alarm     = st_r.sdb_al;
  assign mib_alarm     = st_r.mib_al;
  assign mib_rsp_vld   = st_r.rsp_vld;
  assign mib_rsp_data  = st_r.rsp;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_manual_rt_trip: assert property (
    s_man_rt |=> !rtb_uv_out && !rtb_shunt_out)
    else $error("manual trip did not drop breaker outputs");

  chk_copies_two_three: assert property (
    $countones(rt_if.vote) >= 2 |=> !rtb_uv_out && !rtb_shunt_out)
    else $error("two vote copies did not trip");

  chk_esf_all_open: assert property (
    auto_esf |=> esf_sw_out == 4'h0)
    else $error("switching outputs not all open");

  chk_heater_both: assert property (
    (s_man_esf || auto_esf) |=> !phb_uv_out && !phb_shunt_out)
    else $error("heater breaker outputs still energised");

  chk_pcs_gated: assert property (
    !s_pcs_en && !s_man_rt && !auto_rt |=> rtb_uv_out)
    else $error("plant control acted while disabled");

  chk_bus_fail_alarm: assert property (
    (|sdb_fail) |=> ((sdb_alarm & $past(sdb_fail)) == $past(sdb_fail))
                    && !rtb_uv_out)
    else $error("bus failure without alarm and trip");

  chk_mib_silent: assert property (
    $past(st_r.mib_dead) |-> !mib_rsp_vld)
    else $error("answer after monitoring bus failure");

  chk_rt_priority: assert property (
    s_man_rt |=> st_r.rt_src == svpl_pkg::SVPL_SRC_MAN)
    else $error("manual trip not highest priority");
endmodule // svpl_top
`default_nettype wire

// ### tb/svpl_far_end_model.sv
// Far-side model: data bus masters and breaker or valve feedback
`timescale 1ns/100ps
`default_nettype none
module svpl_far_end_model #(
  parameter int FRAME  = 4,
  parameter int FB_DLY = 3
) (
  input  wire logic            sys_clk,
  input  wire logic            rst,
  input  wire logic [2:0][3:0] rt_req,
  input  wire logic [2:0][3:0] esf_req,
  input  wire logic [2:0][3:0] grp_ok,
  input  wire logic [2:0]      beat_stop,
  input  wire logic            rtb_uv_out,
  input  wire logic            phb_uv_out,
  input  wire logic [3:0]      esf_sw_out,
  output var  logic [2:0][3:0] sdb_rt_dmd,
  output var  logic [2:0][3:0] sdb_esf_dmd,
  output var  logic [2:0][3:0] sdb_vld,
  output var  logic [2:0]      sdb_beat,
  output var  logic            rtb_closed,
  output var  logic            phb_closed,
  output var  logic [1:0]      esf_pos
);
  logic [7:0]             frame_cnt;
  logic [FB_DLY-1:0][3:0] fb_pipe;

  ////////////////////////////////////////////////////////////
  // A stopped master freezes its beat, so the far end sees a dead bus
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      frame_cnt   <= 8'h00;
      sdb_beat    <= 3'b000;
      sdb_rt_dmd  <= '0;
      sdb_esf_dmd <= '0;
      sdb_vld     <= '0;
    end else begin
      frame_cnt   <= (frame_cnt == 8'(FRAME - 1)) ? 8'h00 : frame_cnt + 8'h01;
      sdb_rt_dmd  <= rt_req;
      sdb_esf_dmd <= esf_req;
      sdb_vld     <= grp_ok;
      if (frame_cnt == 8'(FRAME - 1)) begin
        sdb_beat <= sdb_beat ^ ~beat_stop;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // Contacts move a few cycles after the drive, never at once
  always_ff @(posedge sys_clk) begin
    fb_pipe <= {fb_pipe[FB_DLY-2:0],
                {rtb_uv_out, phb_uv_out, esf_sw_out[2], esf_sw_out[0]}};
  end
  assign {rtb_closed, phb_closed, esf_pos} = fb_pipe[FB_DLY-1];
endmodule // svpl_far_end_model
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the vote and priority logic
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam logic [15:0] TMO = 16'h0010;
  localparam int          LIMIT = 5000;
  localparam logic [7:0] CI [7] = '{8'h0F, 8'h1F, 8'h12, 8'h52, 8'h20,
                                     8'h98, 8'hC0};
  localparam logic [9:0] CE [7] = '{10'h3FC, 10'h001, 10'h3CC, 10'h0CF,
                                     10'h300, 10'h0FE, 10'h0FF};
  logic            sys_clk = 1'b0;
  logic            rst = 1'b1;
  logic [2:0][3:0] rt_req = '0, esf_req = '0, grp_ok = '1;
  logic [2:0]      beat_stop = 3'b000;
  logic            man_rt = 1'b0, man_esf = 1'b0, pcs_enable = 1'b0;
  logic            pcs_rt_open = 1'b0, pcs_phb_open = 1'b0;
  logic [1:0]      pcs_esf_act = 2'b00;
  logic            mib_poll = 1'b0, mib_err = 1'b0;
  logic [3:0]      reg_addr = 4'h0;
  logic [31:0]     reg_wdata = 32'h0000_0000;
  logic            reg_wr = 1'b0, reg_rd = 1'b0;
  logic [2:0][3:0] sdb_rt_dmd, sdb_esf_dmd, sdb_vld;
  logic [2:0]      sdb_beat, sdb_alarm;
  logic            rtb_closed, phb_closed, rtb_uv_out, rtb_shunt_out;
  logic            phb_uv_out, phb_shunt_out, mib_alarm, mib_rsp_vld;
  logic [1:0]      esf_pos;
  logic [3:0]      esf_sw_out;
  logic [31:0]     reg_rdata, rd_v;
  logic [15:0]     mib_rsp_data, mib_v;
  logic            t, e, got;
  int              fails = 0, n_checks = 0, cyc = 0;
  wire logic [7:0] outs;

  assign outs = {rtb_uv_out, rtb_shunt_out, esf_sw_out, phb_uv_out,
                 phb_shunt_out};

  svpl_far_end_model far (.sys_clk(sys_clk), .rst(rst), .rt_req(rt_req),
    .esf_req(esf_req), .grp_ok(grp_ok), .beat_stop(beat_stop),
    .rtb_uv_out(rtb_uv_out), .phb_uv_out(phb_uv_out),
    .esf_sw_out(esf_sw_out), .sdb_rt_dmd(sdb_rt_dmd),
    .sdb_esf_dmd(sdb_esf_dmd), .sdb_vld(sdb_vld), .sdb_beat(sdb_beat),
    .rtb_closed(rtb_closed), .phb_closed(phb_closed), .esf_pos(esf_pos));

  svpl_top #(.SDB_TMO_CYC(TMO)) dut (.sys_clk(sys_clk), .rst(rst),
    .sdb_rt_dmd(sdb_rt_dmd), .sdb_esf_dmd(sdb_esf_dmd), .sdb_vld(sdb_vld),
    .sdb_beat(sdb_beat), .man_rt(man_rt), .man_esf(man_esf),
    .pcs_enable(pcs_enable), .pcs_rt_open(pcs_rt_open),
    .pcs_esf_act(pcs_esf_act), .pcs_phb_open(pcs_phb_open),
    .rtb_closed(rtb_closed), .phb_closed(phb_closed), .esf_pos(esf_pos),
    .mib_poll(mib_poll), .mib_err(mib_err), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rtb_uv_out(rtb_uv_out),
    .rtb_shunt_out(rtb_shunt_out), .esf_sw_out(esf_sw_out),
    .phb_uv_out(phb_uv_out), .phb_shunt_out(phb_shunt_out),
    .sdb_alarm(sdb_alarm), .mib_alarm(mib_alarm),
    .mib_rsp_vld(mib_rsp_vld), .mib_rsp_data(mib_rsp_data));

  always #5 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Hang guard: the whole run needs well under two thousand cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      fails++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // One poll; the answer pulse is caught in its only cycle
  task automatic mib_ask(output logic ok, output logic [15:0] d);
    @(posedge sys_clk);
    mib_poll <= ~mib_poll;
    ok = 1'b0;
    d = 16'h0000;
    for (int k = 0; k < 8; k++) begin
      @(posedge sys_clk);
      #1;
      if (mib_rsp_vld === 1'b1) begin
        ok = 1'b1;
        d = mib_rsp_data;
      end
    end
  endtask

  // Expected drive outputs; a trip or an open switch reads low
  function automatic logic [7:0] exp_o(input logic rt,
                                       input logic [3:0] off,
                                       input logic ph);
    return {~rt, ~rt, ~off, ~ph, ~ph};
  endfunction

  ////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    tick(20);
    chk(32'(outs), 32'(exp_o(1'b0, 4'h0, 1'b0)));
    chk(32'(sdb_alarm), 32'h0000_0000);
    for (int p = 0; p < 16; p++) begin
      @(posedge sys_clk);
      rt_req <= {3{4'(p)}};
      esf_req <= {3{~4'(p)}};
      tick(6);
      t = $countones(4'(p)) >= 2;
      e = $countones(~4'(p)) >= 2;
      chk(32'(outs), 32'(exp_o(t, {4{e}}, e)));
      reg_read(svpl_pkg::REG_STATUS, rd_v);
      chk(32'(rd_v[5:4]), 32'({e, t}));
    end
    $display("group vote done");
    esf_req <= '0;
    for (int m = 0; m < 8; m++) begin
      @(posedge sys_clk);
      for (int b = 0; b < 3; b++) rt_req[b] <= m[b] ? 4'h3 : 4'h0;
      tick(6);
      t = $countones(3'(m)) >= 2;
      chk(32'(outs), 32'(exp_o(t, 4'h0, 1'b0)));
    end
    $display("bus copy vote done");
    @(posedge sys_clk);
    rt_req <= '0;
    for (int i = 0; i < 2; i++) begin
      @(posedge sys_clk);
      grp_ok <= {3{i == 0 ? 4'hE : 4'hA}};
      tick(6);
      t = (i == 1);
      chk(32'(outs), 32'(exp_o(t, {4{t}}, t)));
    end
    grp_ok <= '1;
    beat_stop <= 3'b010;
    tick(30);
    chk(32'(outs), 32'(exp_o(1'b1, 4'hF, 1'b1)));
    chk(32'(sdb_alarm), 32'h0000_0002);
    reg_read(svpl_pkg::REG_STATUS, rd_v);
    chk(32'(rd_v[2:0]), 32'h0000_0002);
    beat_stop <= 3'b000;
    tick(30);
    reg_write(svpl_pkg::REG_ALARM, 32'h0000_0002);
    reg_read(svpl_pkg::REG_ALARM, rd_v);
    chk(rd_v, 32'h0000_0000);
    reg_write(svpl_pkg::REG_STATUS, 32'hFFFF_FFFF);
    reg_read(svpl_pkg::REG_STATUS, rd_v);
    chk(rd_v, 32'h0000_0000);
    reg_read(4'h8, rd_v);
    chk(rd_v, 32'h0000_0000);
    chk(32'(outs), 32'(exp_o(1'b0, 4'h0, 1'b0)));
    $display("bus failure done");
    for (int i = 0; i < 7; i++) begin
      @(posedge sys_clk);
      rt_req <= {3{CI[i][7] ? 4'h3 : 4'h0}};
      {man_rt, man_esf, pcs_enable, pcs_rt_open, pcs_esf_act,
       pcs_phb_open} <= CI[i][6:0];
      tick(6);
      reg_read(svpl_pkg::REG_STATUS, rd_v);
      chk(32'({outs, rd_v[7:6]}), 32'(CE[i]));
    end
    $display("priority done");
    @(posedge sys_clk);
    {man_rt, man_esf, pcs_enable, pcs_rt_open, pcs_esf_act,
     pcs_phb_open} <= 7'h00;
    rt_req <= '0;
    tick(10);
    mib_ask(got, mib_v);
    chk(32'({got, mib_v}), 32'h0001_000F);
    rt_req <= {3{4'h3}};
    tick(10);
    mib_ask(got, mib_v);
    chk(32'({got, mib_v}), 32'h0001_008E);
    rt_req <= '0;
    mib_err <= 1'b1;
    tick(10);
    mib_ask(got, mib_v);
    chk(32'(got), 32'h0000_0000);
    chk(32'({mib_alarm, outs}), 32'({1'b1, exp_o(1'b0, 4'h0, 1'b0)}));
    $display("monitoring done");
    @(posedge sys_clk);
    rst <= 1'b1;
    mib_err <= 1'b0;
    tick(2);
    chk(32'({mib_alarm, sdb_alarm, outs}), 32'h0000_0000);
    rst <= 1'b0;
    tick(20);
    chk(32'({mib_rsp_vld, mib_rsp_data}), 32'h0000_0000);
    mib_ask(got, mib_v);
    chk(32'(got), 32'h0000_0001);
    $display("second reset done");
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
